// ==== hdl/board_reset_cfg.svh ====
`ifndef BOARD_RESET_CFG_SVH
`define BOARD_RESET_CFG_SVH

// Register byte addresses
`define ADDR_CTRL        12'h000
`define ADDR_STATUS      12'h004
`define ADDR_LOCMON      12'h008

// Control register fields
`define CTRL_ABORT_EN    0
`define CTRL_RSTSW_DIS   1
`define CTRL_SYSRST_REQ  2
`define CTRL_LOCAL_HOLD  3
`define CTRL_LEVEL_LSB   4
`define CTRL_RESET       32'h0000_0000

// Status register fields
`define STAT_ABORT_PEND  0
`define STAT_SYSCON      1
`define STAT_SYSRST_OUT  2
`define STAT_LOCAL_RST   3

// Timing
`define CLK_PERIOD_NS    5
`define SYSRST_MIN_MS    200
`define SYSRST_CYCLES    ((`SYSRST_MIN_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_CYCLES  16'hFFFF

`endif

// ==== hdl/board_reset_pkg.sv ====
package board_reset_pkg;
  typedef logic [2:0]  irq_level_t;
  typedef logic [3:0]  locmon_t;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;
  typedef enum logic [0:0] {STR_IDLE, STR_HOLD} stretch_t;
endpackage

// ==== hdl/board_reset_abort_indicators.sv ====
`timescale 1ns/1ps
`include "board_reset_cfg.svh"

module board_reset_abort_indicators #(
  parameter int unsigned SYSRST_CYCLES = `SYSRST_CYCLES, // Backplane reset stretch
  parameter bit          HAS_BACKPLANE = 1'b1            // Backplane option fitted
) (
  input  wire logic                       MCLK,            // 200 MHz clock
  input  wire logic                       RST,             // Sync reset, high
  input  wire logic                       CE,              // Clock enable
  input  wire logic                       PSEL,            // APB select
  input  wire logic                       PENABLE,         // APB enable
  input  wire logic                       PWRITE,          // APB direction
  input  wire board_reset_pkg::addr_t     PADDR,           // APB address
  input  wire board_reset_pkg::word_t     PWDATA,          // APB write data
  output board_reset_pkg::word_t          PRDATA,          // APB read data
  output logic                            PREADY,          // APB ready
  output logic                            PSLVERR,         // APB error
  input  wire logic                       POWER_UP_RST,    // Power-up reset request
  input  wire logic                       WATCHDOG_TMO,    // Watchdog timeout
  input  wire logic                       ABORT_SW_N,      // Abort button, low pressed
  input  wire logic                       RESET_SW_N,      // Reset button, low pressed
  input  wire logic                       SYSCON_SEL,      // Board is system controller
  input  wire logic                       SYSRESET_IN_N,   // Backplane reset input
  input  wire logic                       GLOBAL_RST_BIT,  // Global control reset bit
  input  wire board_reset_pkg::locmon_t   LOCMON_IN,       // Location monitor hits
  input  wire logic                       board_failure_n, // Board failure, low active
  input  wire logic                       CPU_HALT,        // Processor halt status
  input  wire logic                       transfer_in_progress_n, // Local cycle, low
  input  wire logic                       NET_MASTER,      // Network owns local bus
  input  wire logic                       DISK_MASTER,     // Disk ctrl owns local bus
  input  wire logic                       BP_STROBE_OUT,   // Board drives address strobe
  input  wire logic                       BP_SLAVE_ACCESS, // Bridge is local bus master
  output logic                            ABORT_IRQ,       // Abort interrupt request
  output board_reset_pkg::irq_level_t     ABORT_IRQ_LEVEL, // Programmed level
  output logic                            SYSRESET_OUT_N,  // Backplane reset drive, low
  output logic                            LOCAL_RST,       // On-board reset
  output board_reset_pkg::locmon_t        LOCMON_OUT,      // Location monitor bits
  output logic                            FAIL_LED,        // Red
  output logic                            HALT_LED,        // Yellow
  output logic                            RUN_LED,         // Green
  output logic                            controller_indicator, // Green
  output logic                            NET_LED,         // Green
  output logic                            DISK_LED,        // Green
  output logic                            BP_LED           // Green
);
  import board_reset_pkg::*;

  typedef struct packed {
    logic        ab_s1;
    logic        ab_s2;
    logic        ab_stable;
    logic [15:0] ab_cnt;
    logic        rs_s1;
    logic        rs_s2;
    logic        abort_en;
    logic        rstsw_dis;
    logic        sysrst_req;
    logic        local_hold;
    irq_level_t  level;
    logic        abort_pend;
    stretch_t    st;
    logic [31:0] st_cnt;
    locmon_t     locmon;
    word_t       prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        sysrst_n;
    logic        local_rst;
    logic [6:0]  leds;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic setup;
  logic wr;
  logic abort_edge;
  logic button;
  logic bp_req;

  always_comb begin
    s_d     = s_q;
    setup   = PSEL && !PENABLE;
    // Writes land at the access edge, where the master sees PREADY high
    wr      = PSEL && PENABLE && PWRITE && s_q.pready;
    button  = 1'b0;
    bp_req  = 1'b0;
    abort_edge = 1'b0;

    // Sync both buttons; only the second stage is looked at
    s_d.ab_s1 = !ABORT_SW_N;
    s_d.ab_s2 = s_q.ab_s1;
    s_d.rs_s1 = !RESET_SW_N;
    s_d.rs_s2 = s_q.rs_s1;

    // Accept new abort level only after a stable window; edge on press
    if (s_q.ab_s2 == s_q.ab_stable) begin
      s_d.ab_cnt = 16'h0000;
    end else if (s_q.ab_cnt == `DEBOUNCE_CYCLES) begin
      s_d.ab_cnt    = 16'h0000;
      s_d.ab_stable = s_q.ab_s2;
      abort_edge    = s_q.ab_s2;
    end else begin
      s_d.ab_cnt = s_q.ab_cnt + 16'h0001;
    end

    // Software-disable gates the reset button
    button = s_q.rs_s2 && !s_q.rstsw_dis;

    // Sources of backplane reset, only when controller
    bp_req = SYSCON_SEL && HAS_BACKPLANE &&
             (button || POWER_UP_RST || WATCHDOG_TMO || s_q.sysrst_req);

    // Stretch restarts on every request
    if (bp_req) begin
      s_d.st     = STR_HOLD;
      s_d.st_cnt = 32'h0000_0000;
    end else begin
      unique case (s_q.st)
        STR_IDLE: s_d.st_cnt = 32'h0000_0000;
        STR_HOLD: begin
          if (s_q.st_cnt >= SYSRST_CYCLES - 1) begin
            s_d.st = STR_IDLE;
          end else begin
            s_d.st_cnt = s_q.st_cnt + 32'h0000_0001;
          end
        end
      endcase
    end
    s_d.sysrst_n = !(bp_req || s_d.st == STR_HOLD);

    // Local reset regardless of controller role
    s_d.local_rst = button || POWER_UP_RST || WATCHDOG_TMO ||
                    (HAS_BACKPLANE && (!SYSRESET_IN_N || GLOBAL_RST_BIT ||
                                       s_q.local_hold));

    // Abort pending flag: set beats clear
    if (wr && PADDR == `ADDR_STATUS && PWDATA[`STAT_ABORT_PEND]) begin
      s_d.abort_pend = 1'b0;
    end
    if (abort_edge && s_q.abort_en) begin
      s_d.abort_pend = 1'b1;
    end
    s_d.irq = s_d.abort_pend && s_q.abort_en;

    // Location monitor bits latch hits; software write-one clears
    if (wr && PADDR == `ADDR_LOCMON) begin
      s_d.locmon = s_q.locmon & ~PWDATA[3:0];
    end
    s_d.locmon = s_d.locmon | LOCMON_IN;

    if (wr && PADDR == `ADDR_CTRL) begin
      s_d.abort_en   = PWDATA[`CTRL_ABORT_EN];
      s_d.rstsw_dis  = PWDATA[`CTRL_RSTSW_DIS];
      s_d.sysrst_req = HAS_BACKPLANE && PWDATA[`CTRL_SYSRST_REQ];
      s_d.local_hold = HAS_BACKPLANE && PWDATA[`CTRL_LOCAL_HOLD];
      s_d.level      = PWDATA[`CTRL_LEVEL_LSB +: 3];
    end

    // APB slave: answers in the access cycle, zero wait
    s_d.pready  = setup;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      unique case (PADDR)
        `ADDR_CTRL: begin
          s_d.prdata[`CTRL_ABORT_EN]       = s_q.abort_en;
          s_d.prdata[`CTRL_RSTSW_DIS]      = s_q.rstsw_dis;
          s_d.prdata[`CTRL_SYSRST_REQ]     = s_q.sysrst_req;
          s_d.prdata[`CTRL_LOCAL_HOLD]     = s_q.local_hold;
          s_d.prdata[`CTRL_LEVEL_LSB +: 3] = s_q.level;
        end
        `ADDR_STATUS: begin
          s_d.prdata[`STAT_ABORT_PEND] = s_q.abort_pend;
          s_d.prdata[`STAT_SYSCON]     = SYSCON_SEL;
          s_d.prdata[`STAT_SYSRST_OUT] = !s_q.sysrst_n;
          s_d.prdata[`STAT_LOCAL_RST]  = s_q.local_rst;
        end
        `ADDR_LOCMON: s_d.prdata[3:0] = s_q.locmon;
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // Front panel lights
    s_d.leds[0] = !board_failure_n;
    s_d.leds[1] = CPU_HALT;
    s_d.leds[2] = !transfer_in_progress_n;
    s_d.leds[3] = SYSCON_SEL && HAS_BACKPLANE;
    s_d.leds[4] = NET_MASTER;
    s_d.leds[5] = DISK_MASTER;
    s_d.leds[6] = HAS_BACKPLANE && (BP_STROBE_OUT || BP_SLAVE_ACCESS);
  end

  // No bus timer here: a non-controller board relies on the system's global timeout
  always_ff @(posedge MCLK) begin
    if (RST) begin
      s_q          <= '0;
      s_q.st       <= STR_HOLD;
      s_q.sysrst_n <= 1'b0;
      s_q.local_rst <= 1'b1;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign PRDATA               = s_q.prdata;
  assign PREADY               = s_q.pready;
  assign PSLVERR              = s_q.pslverr;
  assign ABORT_IRQ            = s_q.irq;
  assign ABORT_IRQ_LEVEL      = s_q.level;
  assign SYSRESET_OUT_N       = s_q.sysrst_n;
  assign LOCAL_RST            = s_q.local_rst;
  assign LOCMON_OUT           = s_q.locmon;
  assign FAIL_LED             = s_q.leds[0];
  assign HALT_LED             = s_q.leds[1];
  assign RUN_LED              = s_q.leds[2];
  assign controller_indicator = s_q.leds[3];
  assign NET_LED              = s_q.leds[4];
  assign DISK_LED             = s_q.leds[5];
  assign BP_LED               = s_q.leds[6];
endmodule

// ==== tb/board_reset_abort_indicators_properties.sv ====
`timescale 1ns/1ps
module board_reset_checker #(
  parameter int unsigned SYSRST_CYCLES = 50 // Stretch length
) (
  input wire logic MCLK, // Clock
  input wire logic RST, // Reset
  input wire logic CE, // Enable
  input wire logic WATCHDOG_TMO, // Watchdog
  input wire logic SYSCON_SEL, // Controller
  input wire logic board_failure_n, // Failure
  input wire logic CPU_HALT, // Halt
  input wire logic transfer_in_progress_n, // Local cycle
  input wire logic BP_STROBE_OUT, // Strobe
  input wire logic BP_SLAVE_ACCESS, // Accessed
  input wire logic SYSRESET_OUT_N, // Backplane reset
  input wire logic LOCAL_RST, // Board reset
  input wire logic FAIL_LED, // Red
  input wire logic HALT_LED, // Yellow
  input wire logic RUN_LED, // Green
  input wire logic controller_indicator, // Green
  input wire logic BP_LED // Green
);
  bit          v_q;
  int unsigned low_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // Lights lag one cycle, so only compare after a live enabled edge
  always_ff @(posedge MCLK) v_q <= CE & !RST;
  // Reset cycles count too: the stretch runs on after reset release
  always_ff @(posedge MCLK) low_q <= SYSRESET_OUT_N ? 0 : low_q + 1;
  property p_fail; v_q |-> FAIL_LED == !$past(board_failure_n); endproperty
  a_fail: assert property (p_fail) else $error("fail light wrong");
  property p_halt; v_q |-> HALT_LED == $past(CPU_HALT); endproperty
  a_halt: assert property (p_halt) else $error("halt light wrong");
  property p_run; !transfer_in_progress_n && CE |=> RUN_LED; endproperty
  a_run: assert property (p_run) else $error("run light dark");
  property p_ctrl; $rose(SYSCON_SEL) && CE |=> controller_indicator; endproperty
  a_ctrl: assert property (p_ctrl) else $error("controller light dark");
  property p_bp; v_q |-> BP_LED == $past(BP_STROBE_OUT || BP_SLAVE_ACCESS); endproperty
  a_bp: assert property (p_bp) else $error("backplane light wrong");
  property p_wdl; WATCHDOG_TMO && CE |-> ##[1:4] LOCAL_RST; endproperty
  a_wdl: assert property (p_wdl) else $error("no local reset");
  property p_wds; WATCHDOG_TMO && SYSCON_SEL && CE |-> ##[1:4] !SYSRESET_OUT_N; endproperty
  a_wds: assert property (p_wds) else $error("no backplane reset");
  property p_str; $rose(SYSRESET_OUT_N) |-> low_q >= SYSRST_CYCLES; endproperty
  a_str: assert property (p_str) else $error("backplane reset short");
endmodule
bind board_reset_abort_indicators board_reset_checker #(.SYSRST_CYCLES(SYSRST_CYCLES)) chk_i (.*);

// ==== tb/backplane_model.sv ====
`timescale 1ns/1ps
module backplane_model (
  input  wire logic board_drive_n, // Board reset drive
  input  wire logic peer_reset, // Another module resets
  output logic      line_n // Shared reset line
);
  // Open-collector line: low while anyone pulls it
  assign line_n = board_drive_n & !peer_reset;
endmodule

// ==== tb/board_reset_abort_indicators_test.sv ====
`timescale 1ns/1ps
`include "board_reset_cfg.svh"
module board_reset_abort_indicators_test;
  import board_reset_pkg::*;
  localparam int unsigned SR = 50;
  logic MCLK = 0, RST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, peer = 0;
  logic POWER_UP_RST = 0, WATCHDOG_TMO = 0, ABORT_SW_N = 1, RESET_SW_N = 1, SYSCON_SEL = 0;
  logic GLOBAL_RST_BIT = 0, board_failure_n = 1, CPU_HALT = 0, transfer_in_progress_n = 1;
  logic NET_MASTER = 0, DISK_MASTER = 0, BP_STROBE_OUT = 0, BP_SLAVE_ACCESS = 0;
  logic PREADY, PSLVERR, ABORT_IRQ, SYSRESET_OUT_N, LOCAL_RST, FAIL_LED, HALT_LED, RUN_LED;
  logic controller_indicator, NET_LED, DISK_LED, BP_LED, er, lo, hit;
  addr_t      PADDR = '0;
  word_t      PWDATA = '0, PRDATA, rd;
  locmon_t    LOCMON_IN = '0, LOCMON_OUT;
  irq_level_t ABORT_IRQ_LEVEL;
  wire        SYSRESET_IN_N;
  int         n_mismatch = 0, cmp_count = 0, n;
  board_reset_abort_indicators #(.SYSRST_CYCLES(SR)) dut (.*);
  backplane_model bp (.board_drive_n(SYSRESET_OUT_N), .peer_reset(peer), .line_n(SYSRESET_IN_N));
  initial forever #2.5 MCLK = ~MCLK;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input addr_t a, input word_t d);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge MCLK);
  endtask
  task watch(input int c);
    lo = 0;
    hit = 0;
    repeat (c) begin
      @(posedge MCLK);
      lo |= LOCAL_RST;
      hit |= !SYSRESET_OUT_N;
    end
  endtask
  task settle;
    n = 0;
    while (SYSRESET_OUT_N !== 1'b1) begin
      @(posedge MCLK);
      n++;
    end
    while (LOCAL_RST !== 1'b0) @(posedge MCLK);
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge MCLK);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge MCLK);
    chk({SYSRESET_OUT_N, LOCAL_RST}, 2'b01);
    RST <= 0;
    settle();
    chk(n >= SR, 1);
    apb(0, `ADDR_CTRL, 0);
    chk(rd, `CTRL_RESET);
    apb(0, 12'h00C, 0);
    chk({er, rd[0]}, 2'b10);
    $display("reset and bus test done");
    for (int k = 0; k < 3; k++) begin
      {board_failure_n, transfer_in_progress_n} <= {2{k != 1}};
      {CPU_HALT, NET_MASTER, DISK_MASTER, SYSCON_SEL, BP_STROBE_OUT} <= {5{k == 1}};
      BP_SLAVE_ACCESS <= k == 2;
      repeat (2) @(posedge MCLK);
      chk({FAIL_LED, HALT_LED, RUN_LED}, {3{k == 1}});
      chk({controller_indicator, NET_LED, DISK_LED}, {3{k == 1}});
      chk(BP_LED, k != 0);
    end
    for (int s = 0; s < 8; s++) begin
      SYSCON_SEL <= s[2];
      {peer, GLOBAL_RST_BIT, POWER_UP_RST, WATCHDOG_TMO} <= 4'h1 << s[1:0];
      watch(8);
      {peer, GLOBAL_RST_BIT, POWER_UP_RST, WATCHDOG_TMO} <= 4'h0;
      chk(lo, 1);
      if (s == 4 || s == 5) chk(hit, 1);
      settle();
    end
    $display("light and source test done");
    apb(1, `ADDR_CTRL, 32'h4);
    apb(1, `ADDR_CTRL, 32'h0);
    settle();
    chk(n >= SR - 3, 1);
    apb(1, `ADDR_CTRL, 32'h2);
    RESET_SW_N <= 0;
    watch(10);
    chk(lo, 0);
    RESET_SW_N <= 1;
    apb(1, `ADDR_CTRL, 32'h0);
    RESET_SW_N <= 0;
    watch(10);
    RESET_SW_N <= 1;
    chk({lo, hit}, 2'b11);
    settle();
    apb(1, `ADDR_CTRL, 32'h8);
    watch(30);
    chk(LOCAL_RST, 1);
    apb(1, `ADDR_CTRL, 32'h0);
    settle();
    LOCMON_IN <= 4'hA;
    @(posedge MCLK);
    LOCMON_IN <= 4'h0;
    repeat (4) @(posedge MCLK);
    apb(0, `ADDR_LOCMON, 0);
    chk(rd, 32'hA);
    apb(1, `ADDR_LOCMON, 32'h2);
    apb(0, `ADDR_LOCMON, 0);
    chk({rd[3:0], LOCMON_OUT}, 8'h88);
    $display("control test done");
    apb(1, `ADDR_CTRL, 32'h51);
    chk(ABORT_IRQ_LEVEL, 3'h5);
    // A short glitch must not count as a press
    ABORT_SW_N <= 0;
    watch(100);
    ABORT_SW_N <= 1;
    watch(10);
    chk(ABORT_IRQ, 0);
    ABORT_SW_N <= 0;
    n = 0;
    while (ABORT_IRQ !== 1'b1) begin
      @(posedge MCLK);
      n++;
    end
    chk(n > 32'hFFFF, 1);
    apb(0, `ADDR_STATUS, 0);
    chk(rd[0], 1);
    apb(1, `ADDR_STATUS, 32'h1);
    watch(100);
    chk(ABORT_IRQ, 0);
    ABORT_SW_N <= 1;
    $display("abort test done");
    tally_and_finish();
  end
endmodule
